/* File: inc/etc_pkg.sv */
// Package with constants and types for the event time counter
package etc_pkg;
    // Counter geometry
    localparam int CNT_W = 16;
    localparam logic [15:0] CNT_ZERO = 16'h0000;
    localparam logic [15:0] CNT_ONE = 16'h0001;
    localparam logic [15:0] CNT_MAX = 16'hFFFF;
    // Clock rate and time bases
    localparam int CLK_HZ = 40_000_000;
    localparam int CLK_PERIOD_PS = 25_000;
    localparam int TB0_PS = 100_000;       // 0.1 us
    localparam int TB1_PS = 1_000_000;     // 1 us
    localparam int TB2_PS = 10_000_000;    // 10 us
    localparam int TB3_PS = 100_000_000;   // 0.1 ms
    localparam int TB4_PS = 1_000_000_000; // 1 ms
    localparam int TB0_CYC = TB0_PS / CLK_PERIOD_PS;
    localparam int TB1_CYC = TB1_PS / CLK_PERIOD_PS;
    localparam int TB2_CYC = TB2_PS / CLK_PERIOD_PS;
    localparam int TB3_CYC = TB3_PS / CLK_PERIOD_PS;
    localparam int TB4_CYC = TB4_PS / CLK_PERIOD_PS;
    localparam int PRE_W = 16;
    // Long trigger threshold: longer than 1.6 us
    localparam int LONG_NS = 1600;
    localparam int LONG_CYC = (LONG_NS * 1000) / CLK_PERIOD_PS;
    localparam int LONG_W = 8;
    // Selector positions
    localparam logic [3:0] POS_RST_LAST = 4'h4;
    localparam logic [3:0] POS_GATE_LAST = 4'h9;
    localparam logic [3:0] POS_TOG_LAST = 4'hE;
    localparam logic [3:0] POS_OCC = 4'hF;
    // Register map (word indices on the plain port)
    localparam int ADDR_W = 4;
    localparam logic [3:0] REG_CTRL = 4'h0;    // [3:0] selector, [5:4] source, [7:6] display
    localparam logic [3:0] REG_CMD = 4'h1;     // [0] manual clear, [1] clear overflow
    localparam logic [3:0] REG_COUNT = 4'h2;   // absolute count
    localparam logic [3:0] REG_STATUS = 4'h3;  // [0] overflow, [1] run, [2] armed
    localparam logic [3:0] REG_STAMP = 4'h4;   // last stamp (display form)
    localparam int CTRL_SEL_LSB = 0;
    localparam int CTRL_SRC_LSB = 4;
    localparam int CTRL_DSP_LSB = 6;
    localparam int CMD_CLR_BIT = 0;
    localparam int CMD_OVC_BIT = 1;
    localparam logic [7:0] CTRL_RESET = 8'h04;
    // Trigger sources
    typedef enum logic [1:0] {
        ETC_SRC_EVENT = 2'b00,
        ETC_SRC_HIGH = 2'b01,
        ETC_SRC_LOW = 2'b10
    } etc_src_t;
    // Display forms
    typedef enum logic [1:0] {
        ETC_DSP_PORT = 2'b00,
        ETC_DSP_ABS = 2'b01,
        ETC_DSP_REL = 2'b10
    } etc_dsp_t;
    // Toggle mode state
    typedef enum logic [1:0] {
        ETC_TG_IDLE = 2'b00,
        ETC_TG_STOP = 2'b01,
        ETC_TG_RUN = 2'b10
    } etc_tg_t;
endpackage

/* File: inc/etc_trig_if.sv */
// Interface carrying the conditioned trigger between modules
`timescale 1ns/1ps
interface etc_trig_if;
    logic level;
    logic rise;
    logic fall;
    logic long_seen;
    modport src (output level, output rise, output fall, output long_seen);
    modport dst (input level, input rise, input fall, input long_seen);
endinterface

/* File: logic/etc_trig_cond.sv */
// Trigger source select, synchroniser and pulse width measure
`timescale 1ns/1ps
module etc_trig_cond
    import etc_pkg::*;
(
    input wire logic clock_i,
    input wire logic rstn_i,
    input wire logic ce_i,
    input wire logic event_trig_i,
    input wire logic trig_high_i,
    input wire logic trig_low_n_i,
    input wire logic [1:0] src_sel_i,
    input wire logic width_en_i,
    etc_trig_if.src trig
);
    logic [2:0] sync1_ff;
    logic [2:0] sync2_ff;
    logic prev_ff;
    logic [LONG_W-1:0] wid_ff;
    logic long_ff;
    logic sel_lvl;
    logic [LONG_W-1:0] nxt_wid;

    // Polarity: low-active line inverted to a high trigger
    assign sel_lvl = (src_sel_i == ETC_SRC_HIGH) ? sync2_ff[1] :
                     (src_sel_i == ETC_SRC_LOW) ? ~sync2_ff[2] : sync2_ff[0]; // RULE_12 RULE_19
    assign trig.level = sel_lvl;
    assign trig.rise = sel_lvl & ~prev_ff;
    assign trig.fall = ~sel_lvl & prev_ff;
    assign trig.long_seen = long_ff;
    // Width counter saturates once past threshold
    assign nxt_wid = (!sel_lvl || !width_en_i) ? '0 :
                     (long_ff ? wid_ff : wid_ff + LONG_W'(1)); // RULE_11

    // Two-stage sync of every source, idle levels at reset
    always_ff @(posedge clock_i) begin
        if (!rstn_i) begin
            sync1_ff <= 3'b100;
            sync2_ff <= 3'b100;
            prev_ff <= 1'b0;
            wid_ff <= '0;
            long_ff <= 1'b0;
        end else if (ce_i) begin
            sync1_ff <= {trig_low_n_i, trig_high_i, event_trig_i}; // RULE_20
            sync2_ff <= sync1_ff; // RULE_20
            prev_ff <= sel_lvl;
            wid_ff <= nxt_wid;
            long_ff <= sel_lvl & width_en_i & (long_ff | (int'(wid_ff) >= LONG_CYC)); // RULE_07
        end
    end
endmodule

/* File: logic/etc_timebase.sv */
// Time base tick generator for the five selectable rates
`timescale 1ns/1ps
module etc_timebase
    import etc_pkg::*;
(
    input wire logic clock_i,
    input wire logic rstn_i,
    input wire logic ce_i,
    input wire logic [2:0] base_i,
    input wire logic restart_i,
    output logic tick_o
);
    logic [PRE_W-1:0] div_ff;
    logic [PRE_W-1:0] dec_ff;
    logic [PRE_W-1:0] pre_ff;
    logic [PRE_W-1:0] top;

    // Lowest stage divides to 0.1 us at base 0, else to 1 us; higher rates chain decades
    assign top = (base_i == 3'd0) ? PRE_W'(TB0_CYC - 1) : PRE_W'(TB1_CYC - 1); // RULE_02
    assign tick_o = (base_i == 3'd0) ? (div_ff == top) :
                    (div_ff == top) && (dec_ff == pre_ff);

    // Decade chain length per base
    always_comb begin
        unique case (base_i)
            3'd2: pre_ff = PRE_W'(TB2_CYC / TB1_CYC - 1);
            3'd3: pre_ff = PRE_W'(TB3_CYC / TB1_CYC - 1);
            3'd4: pre_ff = PRE_W'(TB4_CYC / TB1_CYC - 1);
            default: pre_ff = '0;
        endcase
    end

    // Prescaler counters
    always_ff @(posedge clock_i) begin
        if (!rstn_i) begin
            div_ff <= '0;
            dec_ff <= '0;
        end else if (ce_i) begin
            if (restart_i) begin
                div_ff <= '0;
                dec_ff <= '0;
            end else if (div_ff == top) begin
                div_ff <= '0;
                dec_ff <= (dec_ff >= pre_ff) ? '0 : dec_ff + PRE_W'(1);
            end else begin
                div_ff <= div_ff + PRE_W'(1);
            end
        end
    end
endmodule

/* File: logic/etc_core.sv */
// Event time counter top: modes, counter, stamps and register port
//
// Operation
// RULE_01: Display selects port, absolute or relative value
// RULE_02: Five time bases from 0.1us to 1ms
// RULE_03: Counter wraps to zero past maximum
// RULE_04: Overflow sets a sticky visible indicator
// RULE_05: Positions 0-4: high trigger resets counter
// RULE_06: Positions 5-9: count only while trigger high
// RULE_07: Positions A-E: pulse over 1.6us is long
// RULE_08: After long reset, short pulses toggle counting
// RULE_09: Toggle modes: manual clear stops and zeroes
// RULE_10: Position F counts trigger rising edges
// RULE_11: Pulse width only judged in A-E
// RULE_12: Trigger from event logic or direct inputs
// RULE_13: Default trigger source is event logic
// RULE_14: Paused emulator sends no trigger; overflow acceptable
// RULE_15: Stamp is raw unscaled count
// RULE_16: Counter is 16 bits, max 65535
// RULE_17: Relative is difference; first shows absolute
// RULE_18: Manual clear zeroes the counter
// RULE_19: Direct inputs active high and active low
// RULE_20: All trigger sources synchronised before use
//
// Chosen here: the address map and the address-and-strobe port.
`timescale 1ns/1ps
module etc_core
    import etc_pkg::*;
(
    input wire logic clock_i,
    input wire logic rstn_i,
    input wire logic ce_i,
    input wire logic event_trig_i,
    input wire logic trig_high_i,
    input wire logic trig_low_n_i,
    input wire logic clear_btn_i,
    input wire logic [15:0] logic_analyzer_port_i,
    input wire logic trace_strobe_i,
    input wire logic trace_first_i,
    input wire logic [ADDR_W-1:0] addr_i,
    input wire logic [15:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [15:0] rdata_o,
    output logic [15:0] stamp_o,
    output logic stamp_valid_o,
    output logic [15:0] count_o,
    output logic overflow_o
);
    etc_trig_if trig();

    logic [7:0] ctrl_ff;
    logic [CNT_W-1:0] cnt_ff;
    logic [CNT_W-1:0] nxt_cnt;
    logic [CNT_W-1:0] last_ff;
    logic [15:0] stamp_ff;
    logic stamp_v_ff;
    logic ovf_ff;
    logic [15:0] rdata_ff;
    logic long_d_ff;
    etc_tg_t tg_ff;
    etc_tg_t nxt_tg;
    logic [3:0] sel;
    logic [1:0] src;
    logic [1:0] dsp;
    logic mode_rst;
    logic mode_gate;
    logic mode_tog;
    logic mode_occ;
    logic [2:0] base;
    logic tick;
    logic clr_sw;
    logic ovc_sw;
    logic man_clr;
    logic long_start;
    logic short_end;
    logic cnt_en;
    logic adv;
    logic wrap;
    logic rst_trig;
    logic [15:0] abs_val;
    logic [15:0] rel_val;
    logic [15:0] rd_mux;

    // Map selector position to time base index 0..4; position F gives 5
    function automatic logic [2:0] base_of(input logic [3:0] p);
        logic [3:0] r;
        r = (p <= POS_RST_LAST) ? p :
            (p <= POS_GATE_LAST) ? p - (POS_RST_LAST + 4'h1) :
            p - (POS_GATE_LAST + 4'h1);
        return r[2:0];
    endfunction

    // Register field split
    assign sel = ctrl_ff[CTRL_SEL_LSB +: 4];
    assign src = ctrl_ff[CTRL_SRC_LSB +: 2];
    assign dsp = ctrl_ff[CTRL_DSP_LSB +: 2];
    assign base = base_of(sel); // RULE_02

    // Mode decode from the 16-position selector
    assign mode_rst = (sel <= POS_RST_LAST); // RULE_05
    assign mode_gate = (sel > POS_RST_LAST) && (sel <= POS_GATE_LAST); // RULE_06
    assign mode_tog = (sel > POS_GATE_LAST) && (sel <= POS_TOG_LAST); // RULE_08
    assign mode_occ = (sel == POS_OCC); // RULE_10

    // Command writes: clear and overflow acknowledge
    assign clr_sw = wr_i && (addr_i == REG_CMD) && wdata_i[CMD_CLR_BIT];
    assign ovc_sw = wr_i && (addr_i == REG_CMD) && wdata_i[CMD_OVC_BIT];
    assign man_clr = clr_sw | clear_btn_i; // RULE_18

    // Trigger conditioning
    etc_trig_cond u_trig (
        .clock_i(clock_i),
        .rstn_i(rstn_i),
        .ce_i(ce_i),
        .event_trig_i(event_trig_i),
        .trig_high_i(trig_high_i),
        .trig_low_n_i(trig_low_n_i),
        .src_sel_i(src),
        .width_en_i(mode_tog), // RULE_11
        .trig(trig.src)
    );

    // Time base prescaler, restarted by a reset trigger or a manual clear (not by a wrap)
    etc_timebase u_tb (
        .clock_i(clock_i),
        .rstn_i(rstn_i),
        .ce_i(ce_i),
        .base_i(base),
        .restart_i(rst_trig | man_clr),
        .tick_o(tick)
    );

    // Long pulse detected this cycle; short pulse ends on a fall
    assign long_start = trig.long_seen & ~long_d_ff; // RULE_07
    assign short_end = trig.fall & ~long_d_ff; // RULE_08

    // Toggle state machine for positions A-E
    always_comb begin
        nxt_tg = tg_ff;
        if (!mode_tog || man_clr) begin
            nxt_tg = ETC_TG_IDLE; // RULE_09
        end else if (long_start) begin
            nxt_tg = ETC_TG_STOP; // RULE_07
        end else begin
            unique case (tg_ff)
                ETC_TG_IDLE: nxt_tg = ETC_TG_IDLE;
                ETC_TG_STOP: begin
                    if (short_end) begin
                        nxt_tg = ETC_TG_RUN; // RULE_08
                    end
                end
                ETC_TG_RUN: begin
                    if (short_end) begin
                        nxt_tg = ETC_TG_STOP; // RULE_08
                    end
                end
                default: nxt_tg = ETC_TG_IDLE;
            endcase
        end
    end

    // Counter reset and enable per mode; positions 0-4 run freely between triggers
    assign rst_trig = (mode_rst && trig.level) || (mode_tog && long_start); // RULE_05 RULE_07
    assign cnt_en = mode_rst || (mode_gate && trig.level) || // RULE_05 RULE_06
                    (mode_tog && tg_ff == ETC_TG_RUN); // RULE_08
    assign adv = mode_occ ? trig.rise : (cnt_en && tick); // RULE_10 RULE_02
    assign wrap = adv && (cnt_ff == CNT_MAX) && !rst_trig && !man_clr;

    // Next count: clear dominates, then reset trigger, then advance
    assign nxt_cnt = (man_clr || rst_trig) ? CNT_ZERO : // RULE_18 RULE_05
                     adv ? cnt_ff + CNT_ONE : cnt_ff; // RULE_03 RULE_16

    // Stamp forms: raw absolute count and difference
    assign abs_val = cnt_ff; // RULE_15
    assign rel_val = trace_first_i ? cnt_ff : cnt_ff - last_ff; // RULE_17

    // Register read selection
    always_comb begin
        rd_mux = 16'h0000;
        unique case (addr_i)
            REG_CTRL: rd_mux = {8'h00, ctrl_ff};
            REG_COUNT: rd_mux = cnt_ff;
            REG_STATUS: rd_mux = {13'h0000, (tg_ff != ETC_TG_IDLE), cnt_en, ovf_ff};
            REG_STAMP: rd_mux = stamp_ff;
            default: rd_mux = 16'h0000;
        endcase
    end

    // Control register, selector default position and event source
    always_ff @(posedge clock_i) begin
        if (!rstn_i) begin
            ctrl_ff <= CTRL_RESET; // RULE_13
        end else if (ce_i && wr_i && addr_i == REG_CTRL) begin
            ctrl_ff <= wdata_i[7:0];
        end
    end

    // Counter, toggle state and overflow flag
    always_ff @(posedge clock_i) begin
        if (!rstn_i) begin
            cnt_ff <= CNT_ZERO;
            tg_ff <= ETC_TG_IDLE;
            long_d_ff <= 1'b0;
            ovf_ff <= 1'b0;
        end else if (ce_i) begin
            cnt_ff <= nxt_cnt;
            tg_ff <= nxt_tg;
            long_d_ff <= trig.long_seen | (long_d_ff & trig.level);
            // Set wins over acknowledge
            ovf_ff <= wrap | (ovf_ff & ~ovc_sw); // RULE_04
        end
    end

    // Trace stamp capture per traced cycle
    always_ff @(posedge clock_i) begin
        if (!rstn_i) begin
            last_ff <= CNT_ZERO;
            stamp_ff <= 16'h0000;
            stamp_v_ff <= 1'b0;
        end else if (ce_i) begin
            stamp_v_ff <= trace_strobe_i;
            if (trace_strobe_i) begin
                last_ff <= cnt_ff; // RULE_17
                unique case (dsp)
                    ETC_DSP_ABS: stamp_ff <= abs_val; // RULE_01
                    ETC_DSP_REL: stamp_ff <= rel_val; // RULE_01
                    default: stamp_ff <= logic_analyzer_port_i; // RULE_01
                endcase
            end
        end
    end

    // Read data one cycle after the strobe
    always_ff @(posedge clock_i) begin
        if (!rstn_i) begin
            rdata_ff <= 16'h0000;
        end else if (ce_i) begin
            rdata_ff <= rd_i ? rd_mux : 16'h0000;
        end
    end

    assign rdata_o = rdata_ff;
    assign stamp_o = stamp_ff;
    assign stamp_valid_o = stamp_v_ff;
    assign count_o = cnt_ff;
    assign overflow_o = ovf_ff;
endmodule

/* File: verification/etc_trig_model.sv */
// Trigger source model: event logic and target interrupt lines
`timescale 1ns/1ps
module etc_trig_model (
    input wire logic clock_i,
    output logic event_trig_o,
    output logic trig_high_o,
    output logic trig_low_n_o
);
    // Idle: no source asserts, as with a paused emulator
    initial begin
        event_trig_o = 1'b0;
        trig_high_o = 1'b0;
        trig_low_n_o = 1'b1;
    end
    // One source active for n cycles, then idle for gap cycles
    task automatic pulse(input int src, input int n, input int gap);
        @(posedge clock_i);
        case (src)
            0: event_trig_o <= 1'b1;
            1: trig_high_o <= 1'b1;
            default: trig_low_n_o <= 1'b0;
        endcase
        repeat (n) @(posedge clock_i);
        event_trig_o <= 1'b0;
        trig_high_o <= 1'b0;
        trig_low_n_o <= 1'b1;
        repeat (gap) @(posedge clock_i);
    endtask
endmodule

/* File: verification/etc_core_asserts.sv */
// Port checker for the event time counter
`timescale 1ns/1ps
module etc_core_asserts
    import etc_pkg::*;
(
    input wire logic clock_i,
    input wire logic rstn_i,
    input wire logic ce_i,
    input wire logic event_trig_i,
    input wire logic clear_btn_i,
    input wire logic trace_strobe_i,
    input wire logic [ADDR_W-1:0] addr_i,
    input wire logic [15:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [15:0] rdata_o,
    input wire logic stamp_valid_o,
    input wire logic [15:0] count_o,
    input wire logic overflow_o
);
    logic [7:0] ctrl_ff;
    logic rst_md, gate_md;
    // Shadow of the control word
    always_ff @(posedge clock_i) begin
        if (!rstn_i) begin
            ctrl_ff <= CTRL_RESET;
        end else if (ce_i && wr_i && addr_i == REG_CTRL) begin
            ctrl_ff <= wdata_i[7:0];
        end
    end
    // Mode decode, event source only
    assign rst_md = ctrl_ff[3:0] <= POS_RST_LAST && ctrl_ff[5:4] == 2'b00;
    assign gate_md = ctrl_ff[3:0] > POS_RST_LAST && ctrl_ff[3:0] <= POS_GATE_LAST
        && ctrl_ff[5:4] == 2'b00;
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rstn_i);
    property p_rd_count;
        ce_i && rd_i && addr_i == REG_COUNT |=> rdata_o == $past(count_o);
    endproperty
    a_rd_count: assert property (p_rd_count) else $error("count read wrong");
    property p_rd_ctrl;
        ce_i && rd_i && addr_i == REG_CTRL |=> rdata_o[7:0] == $past(ctrl_ff);
    endproperty
    a_rd_ctrl: assert property (p_rd_ctrl) else $error("control read wrong");
    property p_ovf_hold;
        overflow_o && !(wr_i && addr_i == REG_CMD && wdata_i[CMD_OVC_BIT]) |=> overflow_o;
    endproperty
    a_ovf_hold: assert property (p_ovf_hold) else $error("overflow dropped");
    property p_ovf_wrap;
        $rose(overflow_o) |-> $past(count_o) == CNT_MAX && count_o == CNT_ZERO;
    endproperty
    a_ovf_wrap: assert property (p_ovf_wrap) else $error("overflow without wrap");
    property p_step;
        count_o != $past(count_o) |-> count_o == $past(count_o) + CNT_ONE || count_o == CNT_ZERO;
    endproperty
    a_step: assert property (p_step) else $error("counter jumped");
    property p_stamp;
        ce_i |=> stamp_valid_o == $past(trace_strobe_i);
    endproperty
    a_stamp: assert property (p_stamp) else $error("stamp pulse wrong");
    property p_clear;
        ce_i && clear_btn_i |=> count_o == CNT_ZERO;
    endproperty
    a_clear: assert property (p_clear) else $error("clear ignored");
    property p_trig_rst;
        (rst_md && ce_i && event_trig_i)[*4] |=> count_o == CNT_ZERO;
    endproperty
    a_trig_rst: assert property (p_trig_rst) else $error("trigger did not reset");
    property p_gate_hold;
        (gate_md && ce_i && !event_trig_i && !clear_btn_i && !wr_i)[*4] |=> $stable(count_o);
    endproperty
    a_gate_hold: assert property (p_gate_hold) else $error("gated counter moved");
    property p_freeze;
        !ce_i |=> $stable(count_o) && $stable(overflow_o);
    endproperty
    a_freeze: assert property (p_freeze) else $error("state moved while disabled");
    // Main scenarios reached
    c_trig_rst: cover property (p_trig_rst);
    c_gate: cover property ((gate_md && event_trig_i)[*8]);
    c_stamp: cover property (trace_strobe_i ##1 stamp_valid_o);
endmodule
bind etc_core etc_core_asserts i_chk (.clock_i(clock_i), .rstn_i(rstn_i), .ce_i(ce_i),
    .event_trig_i(event_trig_i), .clear_btn_i(clear_btn_i), .trace_strobe_i(trace_strobe_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .stamp_valid_o(stamp_valid_o), .count_o(count_o), .overflow_o(overflow_o));

/* File: verification/etc_core_bench.sv */
// Self-checking bench for the event time counter
`timescale 1ns/1ps
module etc_core_bench;
    import etc_pkg::*;
    logic clock_i = 1'b0;
    logic rstn_i = 1'b0;
    logic ce_i = 1'b1;
    logic clear_btn_i = 1'b0;
    logic strobe = 1'b0;
    logic first = 1'b0;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic [3:0] addr_i = 4'h0;
    logic [15:0] wdata_i = 16'h0000;
    logic [15:0] port = 16'h0000;
    logic ev, th, tl_n, stamp_valid_o, overflow_o;
    logic [15:0] rdata_o, stamp_o, count_o, v;
    int errors = 0;
    int samples_checked = 0;
    int cycles = 0;
    // 40 MHz clock
    always #12.5 clock_i = ~clock_i;
    etc_trig_model i_trig (.clock_i(clock_i), .event_trig_o(ev), .trig_high_o(th),
        .trig_low_n_o(tl_n));
    etc_core i_dut (.clock_i(clock_i), .rstn_i(rstn_i), .ce_i(ce_i), .event_trig_i(ev),
        .trig_high_i(th), .trig_low_n_i(tl_n), .clear_btn_i(clear_btn_i),
        .logic_analyzer_port_i(port), .trace_strobe_i(strobe), .trace_first_i(first),
        .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
        .stamp_o(stamp_o), .stamp_valid_o(stamp_valid_o), .count_o(count_o),
        .overflow_o(overflow_o));
    task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string m);
        samples_checked++;
        if (seen !== exp) begin
            errors++;
            $display("MISMATCH %0t %s: %h vs %h", $time, m, seen, exp);
        end
    endtask
    task automatic near(input logic [15:0] lo, input logic [15:0] hi, input string m);
        check({15'h0000, count_o >= lo && count_o <= hi}, 16'h0001, m);
    endtask
    task automatic wait_n(input int n);
        repeat (n) @(posedge clock_i);
        #1;
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clock_i);
        wr_i <= 1'b1;
        addr_i <= a;
        wdata_i <= d;
        @(posedge clock_i);
        wr_i <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [15:0] mask, input logic [15:0] exp);
        @(posedge clock_i);
        rd_i <= 1'b1;
        addr_i <= a;
        @(posedge clock_i);
        rd_i <= 1'b0;
        #1;
        check(rdata_o & mask, exp, "read");
    endtask
    task automatic clr();
        @(posedge clock_i);
        clear_btn_i <= 1'b1;
        @(posedge clock_i);
        clear_btn_i <= 1'b0;
        #1;
        check(count_o, CNT_ZERO, "clear");
    endtask
    task automatic trace(input logic f, input logic [15:0] p, input logic [15:0] exp);
        @(posedge clock_i);
        strobe <= 1'b1;
        first <= f;
        port <= p;
        @(posedge clock_i);
        strobe <= 1'b0;
        first <= 1'b0;
        #1;
        check({15'h0000, stamp_valid_o}, 16'h0001, "valid");
        check(stamp_o, exp, "stamp");
    endtask
    task automatic t_regs();
        rd(REG_CTRL, 16'h00FF, 16'h0004);
        wr(4'hF, 16'hFFFF);
        rd(4'hF, 16'hFFFF, 16'h0000);
        rd(REG_CTRL, 16'h00FF, 16'h0004);
        $display("regs done");
    endtask
    task automatic t_bases();
        int cy[3] = '{TB0_CYC, TB1_CYC, TB2_CYC};
        for (int i = 0; i < 3; i++) begin
            wr(REG_CTRL, 16'(i));
            i_trig.pulse(0, 8, 1);
            #1;
            check(count_o, CNT_ZERO, "trigger reset");
            wait_n(10 * cy[i]);
            near(16'h0009, 16'h000A, "time base");
        end
        $display("bases done");
    endtask
    task automatic t_gate();
        wr(REG_CTRL, 16'h0005);
        clr();
        i_trig.pulse(0, 400, 20);
        #1;
        near(16'h0061, 16'h0065, "gated count");
        v = count_o;
        wait_n(100);
        check(count_o, v, "gated hold");
        $display("gate done");
    endtask
    task automatic t_tog();
        wr(REG_CTRL, 16'h000A);
        i_trig.pulse(0, 80, 10);
        #1;
        check(count_o, CNT_ZERO, "long pulse");
        rd(REG_STATUS, 16'h0006, 16'h0004);
        i_trig.pulse(0, 10, 400);
        #1;
        near(16'h005F, 16'h0064, "toggled on");
        i_trig.pulse(0, 60, 5);
        #1;
        v = count_o;
        check({15'h0000, v > 16'h0064}, 16'h0001, "short 60");
        wait_n(100);
        check(count_o, v, "toggled off");
        clr();
        wait_n(100);
        check(count_o, CNT_ZERO, "clear stops");
        $display("toggle done");
    endtask
    task automatic t_occ();
        wr(REG_CTRL, 16'h001F);
        clr();
        repeat (5) i_trig.pulse(1, 3, 4);
        i_trig.pulse(1, 100, 4);
        wr(REG_CTRL, 16'h002F);
        repeat (3) i_trig.pulse(2, 3, 4);
        i_trig.pulse(0, 3, 4);
        #1;
        check(count_o, 16'h0009, "occurrences");
        $display("occurrence done");
    endtask
    task automatic t_stamp();
        wr(REG_CTRL, 16'h005F);
        trace(1'b0, 16'h0000, 16'h0009);
        wr(REG_CTRL, 16'h001F);
        trace(1'b0, 16'hA5C3, 16'hA5C3);
        wr(REG_CTRL, 16'h009F);
        trace(1'b1, 16'h0000, 16'h0009);
        repeat (2) i_trig.pulse(1, 3, 4);
        trace(1'b0, 16'h0000, 16'h0002);
        rd(REG_STAMP, 16'hFFFF, 16'h0002);
        $display("stamp done");
    endtask
    task automatic t_ce();
        wr(REG_CTRL, 16'h0000);
        clr();
        wait_n(40);
        near(16'h0009, 16'h000A, "free run");
        @(posedge clock_i);
        ce_i <= 1'b0;
        wait_n(2);
        v = count_o;
        wait_n(40);
        check(count_o, v, "frozen");
        @(posedge clock_i);
        ce_i <= 1'b1;
        wr(REG_CMD, 16'h0001);
        #1;
        check(count_o, CNT_ZERO, "soft clear");
        check({15'h0000, overflow_o}, 16'h0000, "no overflow");
        $display("enable done");
    endtask
    task automatic end_sim();
        $display("checked %0d mismatches %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    // Hang guard
    always @(posedge clock_i) begin
        cycles++;
        if (cycles > 20000) begin
            errors++;
            end_sim();
        end
    end
    // Main sequence
    initial begin
        repeat (8) @(posedge clock_i);
        rstn_i <= 1'b1;
        t_regs();
        t_bases();
        t_gate();
        t_tog();
        t_occ();
        t_stamp();
        t_ce();
        end_sim();
    end
endmodule
